// ---- shared/host_port_pkg.sv ----
// Purpose: Shared constants and types for the generic parallel host port
// Assumes: One core clock at 10 MHz; the system clock period equals it
// Notes:   All timing counts derive from the figures below
package host_port_pkg;

  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam int          PIX_W           = 4;

  // Strobe and recovery figures in system clock periods plus ns
  localparam int          STROBE_MIN_TS   = 5;
  localparam int          STALL_MAX_TS    = 4;
  localparam int          STALL_MAX_NS    = 2;
  localparam int          RD_DATA_TS      = 4;
  localparam int          WR_SETUP_TS     = 2;
  localparam int          WR_SETUP_NS     = 5;
  localparam int          GAP_RD_TS       = 1;
  localparam int          GAP_WW_TS       = 2;
  localparam int          GAP_WW_NS       = 2;
  localparam int          GAP_WR_TS       = 5;
  localparam int          GAP_WR_NS       = 2;

  // Least times round up, longest times round down
  localparam int          STROBE_CYC      = STROBE_MIN_TS;
  localparam int          STALL_CYC       = STALL_MAX_TS
                                            + (STALL_MAX_NS / CLK_PERIOD_NS);
  localparam int          RD_DATA_CYC     = RD_DATA_TS;
  localparam int          WR_SETUP_CYC    = WR_SETUP_TS
                                            + (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_RD_CYC      = GAP_RD_TS;
  localparam int          GAP_WW_CYC      = GAP_WW_TS
                                            + (GAP_WW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_WR_CYC      = GAP_WR_TS
                                            + (GAP_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset and settle times
  localparam int          RST_HOLD_US     = 1000;
  localparam int          SETTLE_US       = 3000;
  localparam int          RST_HOLD_CYC    = RST_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC      = SETTLE_US * 1000 / CLK_PERIOD_NS;

  localparam int          CNT_W           = 16;
  localparam logic [7:0]  RD_DATA_RESET   = 8'h00;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

endpackage

// ---- shared/host_port_if.sv ----
// Purpose: Pin bundle joining the host end and the device end
// Assumes: Strobes and select are active low
// Notes:   Shared data and stall wires are resolved from the enables
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
  import host_port_pkg::*;
  logic  cs_n;          // Chip select
  addr_t host_addr_bus; // Address
  logic  rd_n;          // Read strobe
  logic  wr_n;          // Write strobe
  data_t host_do;       // Host data out
  logic  host_oe;       // Host drives data
  data_t dev_do;        // Device data out
  logic  dev_oe;        // Device drives data
  logic  stall_o_n;     // Device stall level
  logic  stall_oe;      // Device drives stall
  logic  rst_n;         // Device reset from host
  data_t host_data_bus; // Resolved data
  logic  stall_n;       // Resolved stall, pulled high

  assign host_data_bus = dev_oe ? dev_do : (host_oe ? host_do : '0);
  assign stall_n       = stall_oe ? stall_o_n : 1'b1;

  modport host_end (output cs_n, host_addr_bus, rd_n, wr_n, host_do, host_oe,
                    rst_n, input host_data_bus, stall_n);
  modport dev_end  (input cs_n, host_addr_bus, rd_n, wr_n, rst_n, host_data_bus,
                    output dev_do, dev_oe, stall_o_n, stall_oe);
endinterface
`default_nettype wire

// ---- rtl/host_port_dev.sv ----
// Purpose: Device end of the generic parallel host port with stall output
// Assumes: Strobe and reset pins arrive asynchronously and pass a three-stage sampler; select, address and data are registered once
// Notes:   A small register array stands in for the controller memory
//
// Overview of operation
// RL1: Host holds reset low at least 1 ms
// RL2: Bus accesses ignored while reset is low
// RL3: Panel outputs freeze while reset is low
// RL4: Host waits 3 ms after reset release
// RL5: Host initialises registers soon after reset
// RL6: Strobes stay low at least five periods
// RL7: Stall driven low after strobe falls
// RL8: Stall active at most four periods
// RL9: Read data valid one period after stall
// RL10: Without stall, data valid within four periods
// RL11: Write data set up two periods early
// RL12: Host honours minimum strobe cycle times
// RL13: Host honours minimum strobe inactive times
// RL14: Stall released to float after strobe rises
// RL15: Data driven only during read strobe
// RL16: Input clock at most 60 MHz
// RL17: Address and select stable during strobe
`timescale 1ns/100ps
`default_nettype none
module host_port_dev
  import host_port_pkg::*;
(
  input  wire logic                  i_core_clk,       // Core clock
  input  wire logic                  i_use_stall,      // Stall output enabled
  host_port_if.dev_end               bus,              // Host pins
  output logic [host_port_pkg::PIX_W-1:0] o_panel_pixel_data, // Panel data
  output logic                       o_panel_line_pulse, // Line pulse
  output logic                       o_panel_ac_drive  // AC drive
);
  import host_port_pkg::*;

  typedef enum {ST_IDLE, ST_STALL, ST_DRIVE, ST_WRITE} dev_state_t;

  // Reset pin comes from the host: sample it three times as well
  logic [2:0] rst_sync_reg;
  logic [2:0] rd_sync_reg;
  logic [2:0] wr_sync_reg;
  logic       cs_q_reg;
  addr_t      addr_q_reg;
  data_t      wdat_q_reg;
  logic       rst_ok;
  logic       rd_act;
  logic       wr_act;

  always_ff @(posedge i_core_clk)
  begin
    rst_sync_reg <= {rst_sync_reg[1:0], bus.rst_n};
    rd_sync_reg  <= {rd_sync_reg[1:0], bus.rd_n};
    wr_sync_reg  <= {wr_sync_reg[1:0], bus.wr_n};
    cs_q_reg     <= bus.cs_n;
    addr_q_reg   <= bus.host_addr_bus;
    wdat_q_reg   <= bus.host_data_bus;
  end

  // A level counts once stages two and three agree
  logic rst_lvl_reg;
  logic rd_lvl_reg;
  logic wr_lvl_reg;
  always_ff @(posedge i_core_clk)
  begin
    if (rst_sync_reg[2] == rst_sync_reg[1])
      rst_lvl_reg <= rst_sync_reg[2];
    if (rd_sync_reg[2] == rd_sync_reg[1])
      rd_lvl_reg <= rd_sync_reg[2];
    if (wr_sync_reg[2] == wr_sync_reg[1])
      wr_lvl_reg <= wr_sync_reg[2];
  end

  // Agreeing stages count at once; the registered level only bridges a
  // disagreement, which saves the cycle the read data deadline needs
  logic rd_lvl;
  logic wr_lvl;
  assign rd_lvl = (rd_sync_reg[2] == rd_sync_reg[1]) ? rd_sync_reg[2] : rd_lvl_reg;
  assign wr_lvl = (wr_sync_reg[2] == wr_sync_reg[1]) ? wr_sync_reg[2] : wr_lvl_reg;

  assign rst_ok = rst_lvl_reg && (rst_sync_reg[2] == rst_sync_reg[1] ? rst_sync_reg[2] : 1'b1);
  assign rd_act = !rd_lvl && !cs_q_reg;
  assign wr_act = !wr_lvl && !cs_q_reg;

  // Local memory of 16 bytes, addressed by the low address bits
  data_t      mem_reg [16];
  dev_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  data_t      rdat_reg;
  logic       stall_o_n_reg;
  logic       stall_oe_reg;
  logic       dev_oe_reg;

  always_ff @(posedge i_core_clk)
  begin
    if (!rst_ok)
    begin
      state_reg     <= ST_IDLE; // RL2
      cnt_reg       <= '0;
      rdat_reg      <= RD_DATA_RESET;
      stall_o_n_reg <= 1'b1;
      stall_oe_reg  <= 1'b0;
      dev_oe_reg    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= '0;
          // Preload so the byte is valid as soon as the pins are driven
          rdat_reg <= mem_reg[addr_q_reg[3:0]]; // RL10
          if (rd_act)
          begin
            state_reg     <= ST_STALL;
            stall_oe_reg  <= i_use_stall; // RL7
            stall_o_n_reg <= 1'b0;        // RL7
            dev_oe_reg    <= 1'b1;        // RL15
          end
          else if (wr_act)
          begin
            state_reg     <= ST_WRITE;
            stall_oe_reg  <= i_use_stall; // RL7
            stall_o_n_reg <= 1'b0;
          end
        end
        ST_STALL:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          rdat_reg <= mem_reg[addr_q_reg[3:0]];
          // Stall released before the four period ceiling
          if (cnt_reg == CNT_W'(STALL_CYC - 2))
          begin
            stall_o_n_reg <= 1'b1; // RL8 RL9
            state_reg     <= ST_DRIVE;
          end
        end
        ST_WRITE:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(STALL_CYC - 2))
            stall_o_n_reg <= 1'b1; // RL8
          if (!wr_act)
          begin
            // Data captured at strobe end; setup is the host's duty
            mem_reg[addr_q_reg[3:0]] <= wdat_q_reg; // RL11
            stall_o_n_reg <= 1'b1;
            stall_oe_reg  <= 1'b0; // RL14
            state_reg     <= ST_IDLE;
          end
        end
        ST_DRIVE:
        begin
          if (!rd_act)
          begin
            stall_oe_reg <= 1'b0; // RL14
            dev_oe_reg   <= 1'b0; // RL15
            state_reg    <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign bus.dev_do    = rdat_reg; // RL10
  assign bus.dev_oe    = dev_oe_reg;
  assign bus.stall_o_n = stall_o_n_reg;
  assign bus.stall_oe  = stall_oe_reg;

  // Simple panel scan; frozen while reset is held
  logic [7:0] scan_reg;
  always_ff @(posedge i_core_clk)
  begin
    if (!rst_ok)
    begin
      // Halted at a fixed level; after release only unwritten memory bytes put unknowns on the pixel data
      scan_reg           <= '0;   // RL3
      o_panel_pixel_data <= '0;   // RL3
      o_panel_line_pulse <= 1'b0; // RL3
      o_panel_ac_drive   <= 1'b0; // RL3
    end
    else
    begin
      scan_reg           <= scan_reg + 1'b1;
      o_panel_pixel_data <= mem_reg[scan_reg[3:0]][PIX_W-1:0];
      o_panel_line_pulse <= (scan_reg == 8'hFF);
      if (scan_reg == 8'hFF)
        o_panel_ac_drive <= !o_panel_ac_drive;
    end
  end

endmodule // host_port_dev
`default_nettype wire

// ---- rtl/host_port_host.sv ----
// Purpose: Host end driving the generic parallel port
// Assumes: Runs on the same core clock as the device model
// Notes:   Requests are taken only when o_ready is high
`timescale 1ns/100ps
`default_nettype none
module host_port_host
  import host_port_pkg::*;
#(
  parameter int RST_CYC    = RST_HOLD_CYC, // Reset hold length
  parameter int SETTLE_LEN = SETTLE_CYC    // Settle wait
)(
  input  wire logic                  i_core_clk,  // Core clock
  input  wire logic                  i_rst_n,     // Sync reset, active low
  input  wire logic                  i_use_stall, // Device stall enabled
  input  wire logic                  i_req,       // Access request
  input  wire logic                  i_write,     // 1 write, 0 read
  input  wire host_port_pkg::addr_t  i_addr,      // Access address
  input  wire host_port_pkg::data_t  i_wdata,     // Write data
  output logic                       o_ready,     // Can take request
  output logic                       o_rvalid,    // Read data pulse
  output host_port_pkg::data_t       o_rdata,     // Read data
  host_port_if.host_end              bus          // Pins
);
  import host_port_pkg::*;

  typedef enum {H_RESET, H_SETTLE, H_IDLE, H_STROBE, H_GAP} host_state_t;

  host_state_t      state_reg;
  logic [31:0]      cnt_reg;
  logic             wr_reg;
  logic             last_wr_reg;
  logic [2:0]       stall_sync_reg;
  logic             stall_seen_reg;
  logic             cs_n_reg;
  logic             rd_n_reg;
  logic             wr_n_reg;
  logic             oe_reg;
  logic             rst_pin_reg;
  addr_t            addr_reg;
  data_t            wdat_reg;

  always_ff @(posedge i_core_clk)
    stall_sync_reg <= {stall_sync_reg[1:0], bus.stall_n};

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg   <= H_RESET;
      cnt_reg     <= '0;
      rst_pin_reg <= 1'b0;
      cs_n_reg    <= 1'b1;
      rd_n_reg    <= 1'b1;
      wr_n_reg    <= 1'b1;
      oe_reg      <= 1'b0;
      o_ready     <= 1'b0;
      o_rvalid    <= 1'b0;
      o_rdata     <= RD_DATA_RESET;
      wr_reg      <= 1'b0;
      last_wr_reg <= 1'b0;
      stall_seen_reg <= 1'b0;
      addr_reg    <= '0;
      wdat_reg    <= '0;
    end
    else
    begin
      o_rvalid <= 1'b0;
      cnt_reg  <= cnt_reg + 1;
      case (state_reg)
        H_RESET:
          if (cnt_reg == 32'(RST_CYC - 1)) // RL1
          begin
            rst_pin_reg <= 1'b1;
            cnt_reg     <= '0;
            state_reg   <= H_SETTLE;
          end
        H_SETTLE:
          if (cnt_reg == 32'(SETTLE_LEN - 1)) // RL4
          begin
            o_ready   <= 1'b1; // RL5
            state_reg <= H_IDLE;
          end
        H_IDLE:
          if (i_req)
          begin
            o_ready  <= 1'b0;
            wr_reg   <= i_write;
            addr_reg <= i_addr;  // RL17
            wdat_reg <= i_wdata;
            oe_reg   <= i_write; // RL11
            cs_n_reg <= 1'b0;
            rd_n_reg <= i_write;
            wr_n_reg <= !i_write;
            cnt_reg  <= '0;
            stall_seen_reg <= 1'b0;
            state_reg <= H_STROBE;
          end
        H_STROBE:
        begin
          if (stall_sync_reg[2] == stall_sync_reg[1] && !stall_sync_reg[2])
            stall_seen_reg <= 1'b1;
          // Hold until minimum width, data time and any stall have passed
          if (cnt_reg >= 32'(STROBE_CYC + RD_DATA_CYC + 2)
              && !(i_use_stall && stall_sync_reg[2] == 1'b0)) // RL6 RL10
          begin
            if (!wr_reg)
            begin
              o_rdata  <= bus.host_data_bus; // RL17
              o_rvalid <= 1'b1;
            end
            rd_n_reg    <= 1'b1;
            wr_n_reg    <= 1'b1;
            cs_n_reg    <= 1'b1;
            last_wr_reg <= wr_reg;
            cnt_reg     <= '0;
            state_reg   <= H_GAP;
          end
        end
        H_GAP:
        begin
          oe_reg <= 1'b0;
          // Worst gap covers write then read, and cycle time too
          if (cnt_reg >= 32'(last_wr_reg ? GAP_WR_CYC : GAP_RD_CYC)) // RL12 RL13
          begin
            o_ready   <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: state_reg <= H_RESET;
      endcase
    end
  end

  assign bus.cs_n          = cs_n_reg;
  assign bus.rd_n          = rd_n_reg;
  assign bus.wr_n          = wr_n_reg;
  assign bus.host_addr_bus = addr_reg;
  assign bus.host_do       = wdat_reg;
  assign bus.host_oe       = oe_reg;
  assign bus.rst_n         = rst_pin_reg;

endmodule // host_port_host
`default_nettype wire

// ---- test/host_port_checker.sv ----
// Purpose: Pin timing checks on the host port between both ends
// Assumes: The core clock samples every pin; device reset is rst_n
// Notes:   Bounds of four cycles allow for the three-stage input sampler
`timescale 1ns/100ps
`default_nettype none
module host_port_checker
  import host_port_pkg::*;
(
  input  wire logic                 i_core_clk,    // Core clock
  input  wire logic                 rst_n,         // Device reset
  input  wire logic                 cs_n,          // Chip select
  input  wire host_port_pkg::addr_t host_addr_bus, // Address
  input  wire logic                 rd_n,          // Read strobe
  input  wire logic                 wr_n,          // Write strobe
  input  wire logic                 host_oe,       // Host drives data
  input  wire logic                 dev_oe,        // Device drives data
  input  wire logic                 stall_oe,      // Device drives stall
  input  wire logic                 stall_n        // Resolved stall
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_end;
    $rose(wr_n);
  endsequence
  // Six idle periods cover both write-then-write and write-then-read
  sequence s_idle_after_write;
    (rd_n && wr_n)[*6];
  endsequence

  a_strobe_width: assert property ($fell(rd_n && wr_n) |-> (!rd_n || !wr_n)[*5])
    else $error("strobe shorter than five periods");
  a_write_gap: assert property (s_write_end |-> s_idle_after_write)
    else $error("strobe restarted too soon after a write");
  a_write_setup: assert property (s_write_end |-> $past(host_oe) && $past(host_oe, 3))
    else $error("write data not set up before strobe end");
  a_pins_steady: assert property ((!$past(rd_n) && !rd_n) || (!$past(wr_n) && !wr_n)
    |-> $stable(host_addr_bus) && !cs_n)
    else $error("address or select moved during strobe");
  a_stall_in_strobe: assert property (!stall_n |-> !rd_n || !wr_n)
    else $error("stall low outside a strobe");
  a_stall_bound: assert property ($fell(stall_n) |-> ##[1:4] stall_n)
    else $error("stall held longer than four periods");
  a_stall_float: assert property ($rose(rd_n && wr_n) |-> ##[0:4] !stall_oe)
    else $error("stall still driven after strobe end");
  a_data_after_stall: assert property ($rose(stall_n) && !rd_n |-> ##[0:1] dev_oe)
    else $error("read data late after stall release");
  a_data_start: assert property ($rose(dev_oe) |-> !rd_n && !cs_n)
    else $error("device drove data outside a read");
  a_data_release: assert property ($rose(rd_n) |-> ##[0:4] !dev_oe)
    else $error("device kept driving data after read");
  a_reset_quiet: assert property (disable iff (1'b0) (!rst_n)[*6] |-> !dev_oe && !stall_oe)
    else $error("device drove a pin while held in reset");
  a_read_data_time: assert property ($fell(rd_n) |-> ##[1:4] dev_oe)
    else $error("read data not driven within four periods");
endmodule // host_port_checker
`default_nettype wire

// ---- test/test_generic_host_bus_port_timing.sv ----
// Purpose: Self-checking bench joining host end and device end
// Assumes: Short reset and settle counts keep the run brief
// Notes:   Device memory decodes address bits [3:0], so aliases must match
`timescale 1ns/100ps
`default_nettype none
module test_generic_host_bus_port_timing;
  import host_port_pkg::*;
  logic       i_core_clk  = 1'b0;
  logic       i_rst_n     = 1'b0;
  logic       use_stall   = 1'b0;
  logic       req         = 1'b0;
  logic       write       = 1'b0;
  addr_t      addr        = '0;
  data_t      wdata       = '0;
  logic       ready;
  logic       rvalid;
  data_t      rdata;
  logic [3:0] pix;
  logic       line_pulse;
  logic       ac_drive;
  logic       ac_seen;
  logic       stall_seen;
  int         line_count  = 0;
  int         err_count   = 0;
  int         comparisons = 0;

  host_port_if bus_if ();
  host_port_host #(.RST_CYC(8), .SETTLE_LEN(8)) host_port_host_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_use_stall(use_stall), .i_req(req),
    .i_write(write), .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid),
    .o_rdata(rdata), .bus(bus_if));
  host_port_dev host_port_dev_i (
    .i_core_clk(i_core_clk), .i_use_stall(use_stall), .bus(bus_if),
    .o_panel_pixel_data(pix), .o_panel_line_pulse(line_pulse), .o_panel_ac_drive(ac_drive));
  host_port_checker host_port_checker_i (
    .i_core_clk(i_core_clk), .rst_n(bus_if.rst_n), .cs_n(bus_if.cs_n),
    .host_addr_bus(bus_if.host_addr_bus), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
    .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe), .stall_oe(bus_if.stall_oe),
    .stall_n(bus_if.stall_n));

  always #50 i_core_clk = ~i_core_clk;
  always @(negedge i_core_clk) if (bus_if.stall_n === 1'b0) stall_seen = 1'b1;
  always @(negedge i_core_clk) if (line_pulse === 1'b1) line_count++;

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input data_t got, input data_t exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that runs out counts as a mismatch and ends the run
  task automatic wait_sig(input bit on_rvalid);
    int n;
    n = 0;
    do
    begin
      @(negedge i_core_clk);
      n++;
      if (n > 300)
      begin
        chk(8'h00, 8'h01);
        results();
      end
    end while ((on_rvalid ? rvalid : ready) !== 1'b1);
  endtask

  // For a read, d is the byte expected on the pins
  task automatic access(input logic wr, input addr_t a, input data_t d);
    wait_sig(1'b0);
    @(posedge i_core_clk);
    req   <= 1'b1;
    write <= wr;
    addr  <= a;
    wdata <= d;
    @(posedge i_core_clk);
    req <= 1'b0;
    if (!wr)
    begin
      // The strobe fell at the last edge; pins must hold the byte four periods on
      repeat (4) @(posedge i_core_clk);
      #10;
      chk(bus_if.host_data_bus, d);
      wait_sig(1'b1);
    end
  endtask

  initial
  begin
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    req     <= 1'b1;
    // Let the device enter its reset before taking the halted level
    repeat (3) @(negedge i_core_clk);
    ac_seen = ac_drive;
    // A request held through device reset must start no strobe
    repeat (6)
    begin
      @(negedge i_core_clk);
      chk({4'h0, ready, line_pulse, bus_if.rd_n, bus_if.wr_n}, 8'h03);
      chk({7'h0, ac_drive}, {7'h0, ac_seen});
    end
    @(posedge i_core_clk);
    req <= 1'b0;
    $display("test reset done");
    for (int m = 0; m < 2; m++)
    begin
      wait_sig(1'b0);
      @(posedge i_core_clk);
      use_stall <= m[0];
      stall_seen = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        access(1'b1, addr_t'(16'h1230 + i), data_t'(8'h5A + 8'h11 * i + 8'h40 * m));
        access(1'b0, addr_t'(16'hFED0 + i), data_t'(8'h5A + 8'h11 * i + 8'h40 * m));
        chk(rdata, data_t'(8'h5A + 8'h11 * i + 8'h40 * m));
      end
      // Read after read, highest address first
      for (int i = 3; i >= 0; i--)
      begin
        access(1'b0, addr_t'(16'h0000 + i), data_t'(8'h5A + 8'h11 * i + 8'h40 * m));
        chk(rdata, data_t'(8'h5A + 8'h11 * i + 8'h40 * m));
      end
      chk({7'h0, stall_seen}, {7'h0, m[0]});
      $display("test stall mode %0d done", m);
    end
    // Panel scan must run again once reset is over
    chk({7'h0, line_count > 0}, 8'h01);
    results();
  end
endmodule // test_generic_host_bus_port_timing
`default_nettype wire
